// file: pkg/lpof_params.svh
// Purpose: constants of the lvds pixel output formatter
// Assumes: included by its bare name, definitions only
// Notes: register byte address is four times the index
//
// Summary of operation
// RULE1: dual link puts odd pixel on lanes 0-3, even on lanes 4-7.
// RULE2: pairing restarts at active video rising edge; that pixel is odd.
// RULE3: two-lane input accepted across 50 to 192 MHz pixel clock.
// RULE4: dual link lanes send 7 bits per pixel pair.
// RULE5: dual link drives both clocks at half pixel rate, 57:43.
// RULE6: two-lane single link sends two frames per pixel clock.
// RULE7: replicate equals single link plus lanes 0-3 copied to 4-7.
// RULE8: bit order select from strap level bit 2, or from register.
// RULE9: layout code is strap level low bits: dual, swap, single, replicate.
// RULE10: link strap bit 1 picks 5/20 Mbps, bit 0 twisted/coax input.
// RULE11: 24-bit and 18-bit colour formats, each in two mappings; the code maps 18-bit one way only, ignoring the select.
// RULE12: select high puts colour MSBs on lanes 3/7, low puts LSBs.
// RULE13: each frame is 7 bit periods, clock high 2, low 3, high 2.
// RULE14: three 256 by 8 lookup tables for red, green and blue.
// RULE15: every table entry is writable and readable by registers.
// RULE16: host loads calibrated table values over the serial bus.
// RULE17: white balance stays off until a register bit enables it.
// RULE18: white balance also applies to 18 and 16 bit sources.
// RULE19: swapped dual link puts odd on lanes 4-7, even on 0-3.
// RULE20: one-lane single link sends one frame per pixel clock.
// RULE21: registers at 0x23 bits 4:2 and 0x49 override the straps.
`ifndef LPOF_PARAMS_SVH
`define LPOF_PARAMS_SVH

// register indexes
`define LF_IDX_LINK 10'h023
`define LF_IDX_OUT 10'h049
`define LF_IDX_WBCTL 10'h040
`define LF_IDX_WBADR 10'h041
`define LF_IDX_WBDAT 10'h042
`define LF_IDX_STAT 10'h043

// field positions
`define LF_OVR_BIT 7
`define LF_LINK_HI 4
`define LF_LINK_LO 2
`define LF_WB_EN_BIT 0
`define LF_WB_SEL_HI 2
`define LF_WB_SEL_LO 1
`define LF_D18_BIT 3

// reset values
`define LF_LINK_RST 8'h00
`define LF_OUT_RST 8'h00
`define LF_WBCTL_RST 8'h00
`define LF_WBADR_RST 8'h00

// timing and patterns
`define LF_CLK_WORD 7'b1100011
`define LF_STRAP_WAIT 2'h3
`define LF_PCLK_MIN_MHZ 50
`define LF_PCLK_MAX_MHZ 192

`endif

// file: pkg/lpof_pkg.sv
// Purpose: types of the lvds pixel output formatter
// Assumes: compiled before the design
// Notes: none
package lpof_pkg;

  // output lane layout, coded as the strap level low bits
  typedef enum logic [1:0] {
    LPOF_DUAL   = 2'b00,
    LPOF_SWAP   = 2'b01,
    LPOF_SINGLE = 2'b10,
    LPOF_REPL   = 2'b11
  } lpof_layout_type;

  typedef enum logic {
    PH_ODD  = 1'b0,
    PH_EVEN = 1'b1
  } lpof_phase_type;

  typedef struct packed {
    logic       active_video_flag;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } lpof_pixel_type;

  typedef struct packed {
    logic [7:0][6:0] lane;
    logic [6:0]      lvds_clock_a;
    logic [6:0]      lvds_clock_b;
  } lpof_frame_type;

  typedef struct packed {
    logic            back_channel_20m;
    logic            coax_input;
    logic            msb_lane_select;
    lpof_layout_type layout;
  } lpof_config_type;

endpackage

// file: src/lpof_top.sv
// Purpose: formats recovered pixels onto eight lvds lanes
// Assumes: pixel data stable for 3 core cycles after its clock rises
// Notes: one frame word per strobe, lanes carry 7 bits each
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lpof_params.svh"

module lpof_top (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      pixel_clk_in,
  input  wire lpof_pkg::lpof_pixel_type  pixel_a_in,
  input  wire lpof_pkg::lpof_pixel_type  pixel_b_in,
  input  wire logic                      two_lane_in,
  input  wire logic [2:0]                output_config_strap_in,
  input  wire logic [2:0]                link_config_strap_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [11:0]               paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic [31:0]                    prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  output lpof_pkg::lpof_frame_type       frame_out,
  output logic                           frame_strobe_out,
  output lpof_pkg::lpof_config_type      config_out
);
  import lpof_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_n_meta_q;
  logic rst_n_q;

  // assert at once, release after two edges
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_n_meta_q <= 1'b0;
      rst_n_q      <= 1'b0;
    end else begin
      rst_n_meta_q <= 1'b1;
      rst_n_q      <= rst_n_meta_q;
    end
  end

  // ****************************************
  // pin capture
  // ****************************************
  logic [57:0] s1_q;
  logic [57:0] s2_q;
  logic [57:0] s3_q;
  logic        pclk_lvl_q;
  logic        two_lane_q;
  logic        pix_edge;

  // three stages; data rides with its clock so they stay aligned
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= 58'h0;
      s2_q <= 58'h0;
      s3_q <= 58'h0;
    end else begin
      s1_q <= {link_config_strap_in, output_config_strap_in,
               two_lane_in, pixel_clk_in, pixel_b_in, pixel_a_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level counts only once stages two and three agree
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pclk_lvl_q <= 1'b0;
      two_lane_q <= 1'b0;
    end else begin
      if (s2_q[50] == s3_q[50]) begin
        pclk_lvl_q <= s3_q[50];
      end
      if (s2_q[51] == s3_q[51]) begin
        two_lane_q <= s3_q[51]; // RULE3
      end
    end
  end

  assign pix_edge = s2_q[50] & s3_q[50] & ~pclk_lvl_q;

  // ****************************************
  // strap capture
  // ****************************************
  logic [1:0] wait_q;
  logic       strap_done_q;
  logic [2:0] strap_out_q;
  logic [2:0] strap_link_q;

  // taken once after release, when the pins have settled
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q       <= 2'h0;
      strap_done_q <= 1'b0;
      strap_out_q  <= 3'h0;
      strap_link_q <= 3'h0;
    end else if (!strap_done_q) begin
      if (wait_q != `LF_STRAP_WAIT) begin
        wait_q <= wait_q + 2'h1;
      end else if (s2_q[57:52] == s3_q[57:52]) begin
        strap_out_q  <= s3_q[54:52];
        strap_link_q <= s3_q[57:55];
        strap_done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0]      link_reg_q;
  logic [7:0]      out_reg_q;
  logic [7:0]      wbctl_q;
  logic [7:0]      wbadr_q;
  logic [2:0]      out_lvl;
  logic [2:0]      link_lvl;
  lpof_config_type cfg_q;
  logic            wb_en;
  logic            d18;
  logic [1:0]      wb_sel;

  // register value wins over the strap when its flag is set
  assign out_lvl  = out_reg_q[`LF_OVR_BIT] ? out_reg_q[2:0]
                                            : strap_out_q; // RULE21
  assign link_lvl = link_reg_q[`LF_OVR_BIT]
                  ? link_reg_q[`LF_LINK_HI:`LF_LINK_LO]
                  : strap_link_q; // RULE21
  assign wb_en  = wbctl_q[`LF_WB_EN_BIT]; // RULE17
  assign d18    = wbctl_q[`LF_D18_BIT]; // RULE11
  assign wb_sel = wbctl_q[`LF_WB_SEL_HI:`LF_WB_SEL_LO];

  // decoded configuration, one flop stage
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= '0;
    end else begin
      cfg_q.msb_lane_select  <= out_lvl[2]; // RULE8
      cfg_q.layout <= lpof_layout_type'(out_lvl[1:0]); // RULE9
      cfg_q.back_channel_20m <= link_lvl[1]; // RULE10
      cfg_q.coax_input       <= link_lvl[0]; // RULE10
    end
  end

  assign config_out = cfg_q;

  // ****************************************
  // white balance tables
  // ****************************************
  logic [7:0] lut_q [0:2][0:255];

  // substitute each colour through its own table
  function automatic lpof_pixel_type wb_px(input lpof_pixel_type p,
                                           input logic en);
    wb_px = p;
    if (en) begin
      wb_px.red   = lut_q[0][p.red]; // RULE14
      wb_px.green = lut_q[1][p.green];
      wb_px.blue  = lut_q[2][p.blue];
    end
  endfunction

  // pack one pixel into four 7-bit lane words, lane 3 on top
  function automatic logic [27:0] map_px(input lpof_pixel_type p,
                                         input logic msb,
                                         input logic n18);
    logic [5:0] r6;
    logic [5:0] g6;
    logic [5:0] b6;
    logic [5:0] hi;
    if (msb && !n18) begin
      r6 = p.red[5:0]; // RULE12
      g6 = p.green[5:0];
      b6 = p.blue[5:0];
      hi = {p.blue[7:6], p.green[7:6], p.red[7:6]};
    end else begin
      r6 = p.red[7:2]; // RULE12
      g6 = p.green[7:2];
      b6 = p.blue[7:2];
      hi = {p.blue[1:0], p.green[1:0], p.red[1:0]};
    end
    if (n18) begin
      hi = 6'h00; // RULE11
    end
    map_px = {1'b0, hi, p.active_video_flag, 2'h0, b6[5:2],
              b6[1:0], g6[5:1], g6[0], r6};
  endfunction

  // ****************************************
  // pixel pairing and frames
  // ****************************************
  lpof_pixel_type pend_q;
  logic           pend_v_q;
  lpof_pixel_type push_px;
  logic           push_v;
  logic [27:0]    cur_map;
  logic [27:0]    hold_q;
  lpof_phase_type phase_q;
  logic           last_de_q;
  logic           de_rise;
  logic           is_odd;
  logic           dual;
  logic           repl;
  lpof_frame_type frame_q;
  logic           strobe_q;

  // second pixel of a two-lane edge follows one cycle later
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q   <= '0;
      pend_v_q <= 1'b0;
    end else begin
      pend_v_q <= pix_edge & two_lane_q; // RULE6
      if (pix_edge) begin
        pend_q <= s3_q[49:25];
      end
    end
  end

  assign push_v  = pix_edge | pend_v_q;
  assign push_px = pix_edge ? lpof_pixel_type'(s3_q[24:0]) : pend_q;
  // depth reduction follows the table, so 18/16-bit input still maps
  // a process, not an assign, so a table write re-evaluates the map too
  always_comb begin
    cur_map = map_px(wb_px(push_px, wb_en),
                     cfg_q.msb_lane_select, d18); // RULE18
  end
  assign de_rise = push_px.active_video_flag & ~last_de_q;
  assign is_odd  = de_rise | (phase_q == PH_ODD); // RULE2
  assign dual    = ~cfg_q.layout[1];
  assign repl    = (cfg_q.layout == LPOF_REPL);

  // frame builder; dual layouts emit once per pixel pair
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      frame_q   <= '0;
      strobe_q  <= 1'b0;
      hold_q    <= 28'h0;
      phase_q   <= PH_ODD;
      last_de_q <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      if (push_v) begin
        last_de_q <= push_px.active_video_flag;
        if (!dual) begin
          strobe_q              <= 1'b1; // RULE20
          phase_q               <= PH_ODD;
          frame_q.lane[3:0]     <= cur_map;
          frame_q.lane[7:4]     <= repl ? cur_map : 28'h0; // RULE7
          frame_q.lvds_clock_a  <= `LF_CLK_WORD; // RULE13
          frame_q.lvds_clock_b  <= repl ? `LF_CLK_WORD : 7'h00;
        end else if (is_odd) begin
          hold_q  <= cur_map;
          phase_q <= PH_EVEN;
        end else begin
          strobe_q <= 1'b1; // RULE4
          phase_q  <= PH_ODD;
          if (cfg_q.layout == LPOF_SWAP) begin
            frame_q.lane[7:4] <= hold_q; // RULE19
            frame_q.lane[3:0] <= cur_map;
          end else begin
            frame_q.lane[3:0] <= hold_q; // RULE1
            frame_q.lane[7:4] <= cur_map;
          end
          frame_q.lvds_clock_a <= `LF_CLK_WORD; // RULE5
          frame_q.lvds_clock_b <= `LF_CLK_WORD;
        end
      end
    end
  end

  assign frame_out        = frame_q;
  assign frame_strobe_out = strobe_q;

  // ****************************************
  // apb slave
  // ****************************************
  logic [9:0]  idx;
  logic [31:0] rd_d;
  logic        err_d;
  logic [31:0] prdata_q;
  logic        err_q;
  logic        wr_en;
  logic        wb_ok;

  assign idx   = paddr_in[11:2];
  assign wb_ok = (wb_sel != 2'h3);

  // address decode; misaligned or unknown gives an error
  always_comb begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    if (paddr_in[1:0] != 2'h0) begin
      err_d = 1'b1;
    end else if (idx == `LF_IDX_LINK) begin
      rd_d = {24'h0, link_reg_q};
    end else if (idx == `LF_IDX_OUT) begin
      rd_d = {24'h0, out_reg_q};
    end else if (idx == `LF_IDX_WBCTL) begin
      rd_d = {24'h0, wbctl_q};
    end else if (idx == `LF_IDX_WBADR) begin
      rd_d = {24'h0, wbadr_q};
    end else if (idx == `LF_IDX_WBDAT) begin
      rd_d = wb_ok ? {24'h0, lut_q[wb_sel][wbadr_q]} : 32'h0; // RULE15
    end else if (idx == `LF_IDX_STAT) begin
      rd_d = {24'h0, strap_done_q, two_lane_q, 1'b0, cfg_q};
    end else begin
      err_d = 1'b1;
    end
  end

  // answer prepared in the setup cycle, so no wait states
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_q <= 32'h0;
      err_q    <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_q <= rd_d;
      err_q    <= err_d;
    end
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & err_q;
  assign prdata_out  = prdata_q;
  assign wr_en       = psel_in & penable_in & pwrite_in & ~err_q;

  // register writes; a data write steps the entry index
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      link_reg_q <= `LF_LINK_RST;
      out_reg_q  <= `LF_OUT_RST;
      wbctl_q    <= `LF_WBCTL_RST;
      wbadr_q    <= `LF_WBADR_RST;
    end else if (wr_en) begin
      if (idx == `LF_IDX_LINK) begin
        link_reg_q <= pwdata_in[7:0];
      end else if (idx == `LF_IDX_OUT) begin
        out_reg_q <= pwdata_in[7:0];
      end else if (idx == `LF_IDX_WBCTL) begin
        wbctl_q <= pwdata_in[7:0];
      end else if (idx == `LF_IDX_WBADR) begin
        wbadr_q <= pwdata_in[7:0];
      end else if (idx == `LF_IDX_WBDAT) begin
        wbadr_q <= wbadr_q + 8'h01;
      end
    end
  end

  // table memory has no reset; host loads it before enabling
  always_ff @(posedge core_clk_in) begin
    if (wr_en && idx == `LF_IDX_WBDAT && wb_ok) begin
      lut_q[wb_sel][wbadr_q] <= pwdata_in[7:0]; // RULE16
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_q);

  chk_pair_start: assert property ( // RULE2
    push_v && dual && de_rise |=> phase_q == PH_EVEN && !strobe_q)
    else $error("odd pixel after active edge not held");

  chk_dual_odd_lanes: assert property ( // RULE1
    push_v && !is_odd && cfg_q.layout == LPOF_DUAL
    |=> strobe_q && frame_q.lane[3:0] == $past(hold_q))
    else $error("odd pixel not on low lanes");

  chk_swap_lanes: assert property ( // RULE19
    push_v && !is_odd && cfg_q.layout == LPOF_SWAP
    |=> frame_q.lane[7:4] == $past(hold_q))
    else $error("swapped layout lanes wrong");

  chk_single_rate: assert property ( // RULE20
    push_v && !dual |=> strobe_q ##1 (!strobe_q || $past(pend_v_q)))
    else $error("single link frame missing");

  chk_two_lane_burst: assert property ( // RULE6
    pix_edge && two_lane_q && !dual && $stable(cfg_q)
    |=> strobe_q ##1 strobe_q ##1 !strobe_q)
    else $error("two-lane single link needs two frames");

  chk_clock_shape: assert property ( // RULE13
    strobe_q |-> frame_q.lvds_clock_a == `LF_CLK_WORD)
    else $error("clock word not 4:3");

  chk_dual_clocks: assert property ( // RULE5
    strobe_q && dual |-> frame_q.lvds_clock_b == frame_q.lvds_clock_a)
    else $error("second clock differs in dual link");

  chk_replicate_copy: assert property ( // RULE7
    strobe_q && repl |-> frame_q.lane[7:4] == frame_q.lane[3:0])
    else $error("replicate lanes differ");

  chk_out_decode: assert property ( // RULE9
    !out_reg_q[`LF_OVR_BIT] |=> cfg_q.layout == $past(strap_out_q[1:0])
    && cfg_q.msb_lane_select == $past(strap_out_q[2]))
    else $error("output strap decode wrong");

  chk_link_override: assert property ( // RULE21
    link_reg_q[`LF_OVR_BIT] |=> cfg_q.back_channel_20m == $past(link_reg_q[3])
    && cfg_q.coax_input == $past(link_reg_q[2]))
    else $error("link register override ignored");

  chk_lut_write: assert property ( // RULE15
    wr_en && idx == `LF_IDX_WBDAT && wb_ok
    |=> lut_q[$past(wb_sel)][$past(wbadr_q)] == $past(pwdata_in[7:0]))
    else $error("table entry not written");

  chk_wb_bypass: assert property ( // RULE17
    push_v && !wb_en && !dual && !d18 && !cfg_q.msb_lane_select
    |=> frame_q.lane[0][5:0] == $past(push_px.red[7:2]))
    else $error("pixel altered while balance off");

endmodule

`default_nettype wire

// file: tb/lpof_panel_model.sv
// Purpose: panel side of the lvds output, latches each frame word
// Assumes: one frame word per strobe from the formatter
// Notes: hands the latched word to the bench one cycle later
`timescale 1ns/1ps
`default_nettype none

module lpof_panel_model (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire lpof_pkg::lpof_frame_type frame_in,
  input  wire logic                     strobe_in,
  output lpof_pkg::lpof_frame_type      rx_frame_out,
  output logic                          rx_valid_out
);
  import lpof_pkg::*;

  // ************************************************
  // receiver latch
  // ************************************************
  // the panel only trusts lanes at the strobe, never in between
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_valid_out <= 1'b0;
      rx_frame_out <= '0;
    end else begin
      rx_valid_out <= strobe_in;
      if (strobe_in) begin
        rx_frame_out <= frame_in;
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/lpof_top_tb.sv
// Purpose: self-checking bench of the lvds pixel output formatter
// Assumes: zero-wait apb slave, straps captured once after reset
// Notes: drivers queue expected words, watchers compare them
`timescale 1ns/1ps
`default_nettype none
`include "lpof_params.svh"
`define CMP(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end

module lpof_top_tb;
  import lpof_pkg::*;
  logic            clk, rst_n, pclk, two, psel, pen, pwr, pready, pslverr;
  logic            strobe, rx_valid, wb_en, n18, msb, ph, prev_de;
  logic [2:0]      ostrap, lstrap, lv;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic [33:0]     an;
  logic [3:0][6:0] held;
  logic [7:0]      lut [3][256];
  lpof_pixel_type  pa, pb;
  lpof_frame_type  frame, rx_frame, ef;
  lpof_config_type cfg;
  lpof_layout_type layout;
  logic [33:0]     apb_q [$];
  lpof_frame_type  frm_q [$];
  int              errors, check_count, cycles;

  lpof_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .pixel_clk_in(pclk),
    .pixel_a_in(pa), .pixel_b_in(pb), .two_lane_in(two),
    .output_config_strap_in(ostrap), .link_config_strap_in(lstrap),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .frame_out(frame), .frame_strobe_out(strobe),
    .config_out(cfg));

  lpof_panel_model panel (.clk_in(clk), .rst_n_in(rst_n), .frame_in(frame),
    .strobe_in(strobe), .rx_frame_out(rx_frame), .rx_valid_out(rx_valid));

  // ************************************************
  // expected lane words
  // ************************************************
  // rotate puts the top two bits low so lane 3 carries the msbs
  function automatic logic [3:0][6:0] map4(input lpof_pixel_type p);
    logic [7:0] r, g, b;
    logic       m;
    r = wb_en ? lut[0][p.red] : p.red;
    g = wb_en ? lut[1][p.green] : p.green;
    b = wb_en ? lut[2][p.blue] : p.blue;
    m = msb && !n18;
    r = m ? {r[5:0], r[7:6]} : r;
    g = m ? {g[5:0], g[7:6]} : g;
    b = m ? {b[5:0], b[7:6]} : b;
    map4[3] = n18 ? 7'h00 : {1'b0, b[1:0], g[1:0], r[1:0]};
    map4[2] = {p.active_video_flag, 2'b00, b[7:4]};
    map4[1] = {b[3:2], g[7:3]};
    map4[0] = {g[2], r[7:2]};
  endfunction

  task automatic note_pix(input lpof_pixel_type p);
    logic [3:0][6:0] w;
    lpof_frame_type  f;
    w = map4(p);
    if (p.active_video_flag && !prev_de) ph = 1'b0;
    prev_de = p.active_video_flag;
    f = '0;
    f.lvds_clock_a = `LF_CLK_WORD;
    if (layout == LPOF_DUAL || layout == LPOF_SWAP) begin
      if (!ph) held = w;
      else begin
        f.lvds_clock_b = `LF_CLK_WORD;
        f.lane = (layout == LPOF_DUAL) ? {w, held} : {held, w};
        frm_q.push_back(f);
      end
    end else begin
      f.lane = {(layout == LPOF_REPL) ? w : 28'h0, w};
      if (layout == LPOF_REPL) f.lvds_clock_b = `LF_CLK_WORD;
      frm_q.push_back(f);
    end
    ph = !ph;
  endtask

  // ************************************************
  // drivers
  // ************************************************
  // pixel data held through the whole 800 ns pixel clock period
  task automatic send(input logic de);
    lpof_pixel_type a, b;
    a = {de, 24'($urandom)};
    b = {de, 24'($urandom)};
    @(posedge clk);
    pa <= a;
    pb <= b;
    pclk <= 1'b1;
    note_pix(a);
    if (two) note_pix(b);
    repeat (4) @(posedge clk);
    pclk <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [1:0] lo, input logic [31:0] d,
                     input logic [31:0] e, input logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, lo};
    pwdata <= d;
    apb_q.push_back({!w, er, e});
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // ************************************************
  // watchers
  // ************************************************
  always @(posedge clk) begin
    if (psel && pen && pready) begin
      an = apb_q.pop_front();
      `CMP(pslverr, an[32])
      if (an[33]) `CMP(prdata, an[31:0])
    end
    if (rx_valid) begin
      ef = frm_q.size() ? frm_q.pop_front() : 'x;
      `CMP(rx_frame, ef)
    end
  end

  // hang guard, well beyond the few thousand cycles of the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    void'($urandom(32'hce300e12));
    {rst_n, pclk, two, psel, pen, pwr, paddr, pwdata, pa, pb} = '0;
    {wb_en, n18, msb, ph, prev_de, cycles, errors, check_count} = '0;
    layout = LPOF_DUAL;
    ostrap = 3'($urandom);
    lstrap = 3'($urandom);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    `CMP(cfg, {lstrap[1:0], ostrap})
    apb(0, `LF_IDX_STAT, 0, 0, {24'h0, 3'b100, lstrap[1:0], ostrap}, 0);
    apb(0, `LF_IDX_LINK, 0, 0, 0, 0);
    apb(0, `LF_IDX_OUT, 0, 0, 0, 0);
    apb(0, `LF_IDX_WBCTL, 0, 0, 0, 0);
    apb(0, 10'h3ff, 0, 0, 0, 1);
    apb(0, `LF_IDX_LINK, 2'b01, 0, 0, 1);
    apb(1, 10'h3ff, 0, 32'h55, 0, 1);
    for (int v = 0; v < 8; v++) begin
      lv = 3'(v);
      apb(1, `LF_IDX_LINK, 0, {24'h0, 3'b100, lv, 2'b00}, 0, 0);
      apb(1, `LF_IDX_OUT, 0, {24'h0, 5'b10000, lv}, 0, 0);
      apb(0, `LF_IDX_OUT, 0, 0, {24'h0, 5'b10000, lv}, 0);
      repeat (4) @(posedge clk);
      `CMP(cfg, {lv[1:0], lv})
    end
    // tables loaded red, green, blue; index wraps back to entry 0
    for (int t = 0; t < 3; t++) begin
      apb(1, `LF_IDX_WBCTL, 0, {29'h0, 2'(t), 1'b0}, 0, 0);
      apb(1, `LF_IDX_WBADR, 0, 0, 0, 0);
      for (int i = 0; i < 256; i++) begin
        lut[t][i] = 8'($urandom);
        apb(1, `LF_IDX_WBDAT, 0, {24'h0, lut[t][i]}, 0, 0);
      end
      apb(0, `LF_IDX_WBDAT, 0, 0, {24'h0, lut[t][0]}, 0);
      for (int i = 255; i > 0; i -= 127) begin
        apb(1, `LF_IDX_WBADR, 0, 32'(i), 0, 0);
        apb(0, `LF_IDX_WBDAT, 0, 0, {24'h0, lut[t][i]}, 0);
        apb(0, `LF_IDX_WBDAT, 0, 0, {24'h0, lut[t][i]}, 0);
      end
    end
    apb(1, `LF_IDX_WBCTL, 0, 32'h6, 0, 0);
    apb(0, `LF_IDX_WBDAT, 0, 0, 0, 0);
    // every layout, one and two lanes (replicate one lane only) with lookup off, then every layout on one lane with lookup on
    for (int k = 0; k < 12; k++) begin
      layout = lpof_layout_type'(k[1:0]);
      two <= k[2] && k[1:0] != 2'b11;
      msb = k[0] ^ k[2];
      wb_en = (k >= 8);
      n18 = k[0] & (k[1] | k[3]);
      apb(1, `LF_IDX_OUT, 0, {24'h0, 5'b10000, msb, layout}, 0, 0);
      apb(1, `LF_IDX_WBCTL, 0, {28'h0, n18, 2'b00, wb_en}, 0, 0);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 4; i++) send(1'b1);
      send(1'b0);
      send(1'b0);
    end
    repeat (20) @(posedge clk);
    `CMP(frm_q.size() == 0, 1'b1)
    final_report();
  end

endmodule
`default_nettype wire
